/* File: rtl/sapi_link_rx.sv */
module sapi_link_rx (
	input  wire logic        linkClk,
	input  wire logic        rstn,
	input  wire logic        enable,
	input  wire logic        wordClk,
	input  wire logic        serIn,
	input  wire logic        errIn,
	input  wire logic        cflIn,
	output logic      [31:0] word_q,
	output logic             chan_q,
	output logic             err_q,
	output logic             cfl_q,
	output logic             toggle_q
);
	logic        enSync;
	logic        wcPrev_q;
	logic [31:0] shift_q;
	logic        errAcc_q;
	logic        cflAcc_q;
	logic        wordEdge;

	// Enable is quasi static config, still crossed
	sapi_sync #(.WIDTH(1)) uEnSync (
		.clk  (linkClk),
		.rstn (rstn),
		.d    (enable),
		.q    (enSync)
	);

	assign wordEdge = enSync && (wordClk != wcPrev_q);

	always_ff @(posedge linkClk or negedge rstn) begin
		if (!rstn) begin
			wcPrev_q <= 1'b0;
		end else begin
			wcPrev_q <= wordClk;
		end
	end

	// Flags sampled on the same edge as the data bit
	always_ff @(posedge linkClk or negedge rstn) begin
		if (!rstn) begin
			shift_q  <= 32'h0000_0000;
			errAcc_q <= 1'b0;
			cflAcc_q <= 1'b0;
		end else if (wordEdge) begin
			shift_q  <= {31'h0000_0000, serIn};
			errAcc_q <= errIn;
			cflAcc_q <= cflIn;
		end else begin
			shift_q  <= {shift_q[30:0], serIn};
			errAcc_q <= errAcc_q | errIn;
			cflAcc_q <= cflAcc_q | cflIn;
		end
	end

	// Held a whole word, so the slow side samples it safely
	always_ff @(posedge linkClk or negedge rstn) begin
		if (!rstn) begin
			word_q   <= 32'h0000_0000;
			chan_q   <= 1'b0;
			err_q    <= 1'b0;
			cfl_q    <= 1'b0;
			toggle_q <= 1'b0;
		end else if (wordEdge) begin
			word_q   <= shift_q;
			chan_q   <= wcPrev_q;
			err_q    <= errAcc_q;
			cfl_q    <= cflAcc_q;
			toggle_q <= ~toggle_q;
		end
	end
endmodule // sapi_link_rx

/* File: rtl/sapi_pkg.sv */
package sapi_pkg;

	// ----------------------------------------
	// Pin numbering
	// ----------------------------------------
	localparam int unsigned NUM_PINS = 12;
	localparam int unsigned NUM_IF   = 3;
	localparam int unsigned PIN_BCK1 = 0;
	localparam int unsigned PIN_WCK1 = 3;
	localparam int unsigned PIN_WCK3 = 5;
	localparam int unsigned PIN_SIN1 = 6;
	localparam int unsigned PIN_SIN3 = 7;
	localparam int unsigned PIN_SOUT1 = 8;
	localparam int unsigned PIN_SOUT2 = 9;
	localparam int unsigned PIN_ERR  = 10;
	localparam int unsigned PIN_CFL  = 11;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [7:0] OFF_FUNC   = 8'h00;
	localparam logic [7:0] OFF_CFG    = 8'h04;
	localparam logic [7:0] OFF_GPOUT  = 8'h08;
	localparam logic [7:0] OFF_GPOE   = 8'h0C;
	localparam logic [7:0] OFF_GPIN   = 8'h10;
	localparam logic [7:0] OFF_RXDATA = 8'h14;
	localparam logic [7:0] OFF_RXSTAT = 8'h18;

	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int unsigned CFG_W         = 8;
	localparam int unsigned CFG_BCK_OUT   = 0;
	localparam int unsigned CFG_WCK_OUT   = 3;
	localparam int unsigned CFG_MCLK_EN   = 6;
	localparam int unsigned CFG_TIMER_SEL = 7;
	localparam int unsigned STAT_W        = 5;
	localparam int unsigned STAT_CHAN     = 0;
	localparam int unsigned STAT_ERR      = 1;
	localparam int unsigned STAT_CFL      = 2;
	localparam int unsigned STAT_NEW      = 3;
	localparam int unsigned STAT_OVR      = 4;
	localparam logic [11:0] FUNC_RST  = 12'hFFF;
	localparam logic [7:0]  CFG_RST   = 8'h00;
	localparam logic [11:0] GPIO_RST  = 12'h000;
	localparam logic [4:0]  STAT_RST  = 5'h00;
	localparam logic [1:0]  RESP_OKAY = 2'h0;
	localparam logic [1:0]  RESP_SLV  = 2'h2;

endpackage

/* File: rtl/sapi_sync.sv */
module sapi_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
		end
	end

	assign q = s2_q;
endmodule // sapi_sync

/* File: rtl/sapi_top.sv */
// Contract
// - Each pin selects audio function or GPIO
// - Bit clock pins programmable output or input
// - Bit clock pins are inputs during reset
// - Word clock pins programmable input or output
// - Word clock pins are inputs during reset
// - Clock pin setup held in module registers
// - Word clock three may be master clock
// - Data inputs feed interfaces one and three
// - Data input pins are inputs during reset
// - Data output pins drive during reset
// - Error flag belongs to interface one only
// - C-flag belongs to interface one only
module sapi_top
	import sapi_pkg::*;
(
	input  wire logic                          clk,
	input  wire logic                          rstn,
	input  wire logic                          linkClk,
	input  wire logic [sapi_pkg::ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [sapi_pkg::DATA_W-1:0]   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [sapi_pkg::ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [sapi_pkg::DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic [sapi_pkg::NUM_PINS-1:0] padI,
	output logic [sapi_pkg::NUM_PINS-1:0]      padO,
	output logic [sapi_pkg::NUM_PINS-1:0]      padOe,
	input  wire logic [sapi_pkg::NUM_IF-1:0]   intBitClk,
	input  wire logic [sapi_pkg::NUM_IF-1:0]   intWordClk,
	input  wire logic [1:0]                    intSerOut,
	input  wire logic                          timerOut,
	output logic [sapi_pkg::NUM_IF-1:0]        bitClkToCore,
	output logic [sapi_pkg::NUM_IF-1:0]        wordClkToCore,
	output logic                               masterClkToCore,
	output logic                               masterClkSel,
	output logic                               audioSerIn1,
	output logic                               audioSerIn3,
	output logic                               cdErrorFlag,
	output logic                               cdCFlag
);
	import sapi_pkg::*;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [NUM_PINS-1:0] funcQ;
	logic [CFG_W-1:0]    cfgQ;
	logic [NUM_PINS-1:0] gpOutQ;
	logic [NUM_PINS-1:0] gpOeQ;
	logic [31:0]         rxWordQ;
	logic [STAT_W-1:0]   statQ;
	logic [NUM_PINS-1:0] gpInSync;
	logic [NUM_PINS-1:0] audioO;
	logic [NUM_PINS-1:0] audioOe;

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	logic              awTaken_q;
	logic              wTaken_q;
	logic [ADDR_W-1:0] wAddr_q;
	logic [31:0]       wData_q;
	logic [3:0]        wStrb_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              rvalid_q;
	logic [1:0]        rresp_q;
	logic [31:0]       rdata_q;
	logic [31:0]       rdata_d;
	logic              rdHit;
	logic              wrFire;
	logic              wrHit;
	logic              arFire;
	logic [11:0]       pinMask;

	assign pinMask       = {{4{wStrb_q[1]}}, {8{wStrb_q[0]}}};
	assign s_axi_awready = !awTaken_q && !bvalid_q;
	assign s_axi_wready  = !wTaken_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign wrFire        = awTaken_q && wTaken_q && !bvalid_q;
	assign arFire        = s_axi_arvalid && !rvalid_q;

	assign wrHit = (wAddr_q <= OFF_RXSTAT) && (wAddr_q[1:0] == 2'h0);

	// Address and data taken in either order
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			awTaken_q <= 1'b0;
			wAddr_q   <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awTaken_q <= 1'b1;
			wAddr_q   <= s_axi_awaddr;
		end else if (wrFire) begin
			awTaken_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wTaken_q <= 1'b0;
			wData_q  <= 32'h0000_0000;
			wStrb_q  <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wTaken_q <= 1'b1;
			wData_q  <= s_axi_wdata;
			wStrb_q  <= s_axi_wstrb;
		end else if (wrFire) begin
			wTaken_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else if (wrFire) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wrHit ? RESP_OKAY : RESP_SLV;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	always_comb begin
		rdHit   = 1'b1;
		rdata_d = 32'h0000_0000;
		case (s_axi_araddr)
			OFF_FUNC:   rdata_d[NUM_PINS-1:0] = funcQ;
			OFF_CFG:    rdata_d[CFG_W-1:0] = cfgQ;
			OFF_GPOUT:  rdata_d[NUM_PINS-1:0] = gpOutQ;
			OFF_GPOE:   rdata_d[NUM_PINS-1:0] = gpOeQ;
			OFF_GPIN:   rdata_d[NUM_PINS-1:0] = gpInSync;
			OFF_RXDATA: rdata_d = rxWordQ;
			OFF_RXSTAT: rdata_d[STAT_W-1:0] = statQ;
			default:    rdHit = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
		end else if (arFire) begin
			rvalid_q <= 1'b1;
			rresp_q  <= rdHit ? RESP_OKAY : RESP_SLV;
			rdata_q  <= rdata_d;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Configuration
	// ----------------------------------------
	// Reset leaves every clock pin an input
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			funcQ  <= FUNC_RST;
			cfgQ   <= CFG_RST;
			gpOutQ <= GPIO_RST;
			gpOeQ  <= GPIO_RST;
		end else if (wrFire) begin
			if (wAddr_q == OFF_FUNC) begin
				funcQ <= (funcQ & ~pinMask) | (wData_q[NUM_PINS-1:0] & pinMask);
			end
			if (wAddr_q == OFF_CFG) begin
				cfgQ <= wStrb_q[0] ? wData_q[CFG_W-1:0] : cfgQ;
			end
			if (wAddr_q == OFF_GPOUT) begin
				gpOutQ <= (gpOutQ & ~pinMask) | (wData_q[NUM_PINS-1:0] & pinMask);
			end
			if (wAddr_q == OFF_GPOE) begin
				gpOeQ <= (gpOeQ & ~pinMask) | (wData_q[NUM_PINS-1:0] & pinMask);
			end
		end
	end

	// ----------------------------------------
	// Pin multiplexing
	// ----------------------------------------
	sapi_sync #(.WIDTH(NUM_PINS)) uGpSync (
		.clk  (clk),
		.rstn (rstn),
		.d    (padI),
		.q    (gpInSync)
	);

	always_comb begin
		audioO  = '0;
		audioOe = '0;
		for (int i = 0; i < NUM_IF; i++) begin
			audioO[PIN_BCK1 + i]  = intBitClk[i];
			audioOe[PIN_BCK1 + i] = cfgQ[CFG_BCK_OUT + i];
			audioO[PIN_WCK1 + i]  = intWordClk[i];
			audioOe[PIN_WCK1 + i] = cfgQ[CFG_WCK_OUT + i];
		end
		// Master clock use forces the pin to listen
		if (cfgQ[CFG_MCLK_EN]) begin
			audioOe[PIN_WCK3] = 1'b0;
		end
		// Output one is shared with the timer
		audioO[PIN_SOUT1]  = cfgQ[CFG_TIMER_SEL] ? timerOut : intSerOut[0];
		audioOe[PIN_SOUT1] = 1'b1;
		audioO[PIN_SOUT2]  = intSerOut[1];
		audioOe[PIN_SOUT2] = 1'b1;
	end

	// Data inputs and flag pins never drive in audio mode
	for (genvar p = 0; p < NUM_PINS; p++) begin : gPin
		assign padO[p]  = funcQ[p] ? audioO[p] : gpOutQ[p];
		assign padOe[p] = funcQ[p] ? audioOe[p] : gpOeQ[p];
	end

	// Clock paths are muxes only; no logic samples them here
	for (genvar c = 0; c < NUM_IF; c++) begin : gClk
		assign bitClkToCore[c]  = cfgQ[CFG_BCK_OUT + c] ? intBitClk[c] : padI[PIN_BCK1 + c];
		assign wordClkToCore[c] = cfgQ[CFG_WCK_OUT + c] ? intWordClk[c] : padI[PIN_WCK1 + c];
	end

	assign masterClkToCore = padI[PIN_WCK3] & cfgQ[CFG_MCLK_EN];
	assign masterClkSel    = cfgQ[CFG_MCLK_EN];
	assign audioSerIn1     = padI[PIN_SIN1] & funcQ[PIN_SIN1];
	assign audioSerIn3     = padI[PIN_SIN3] & funcQ[PIN_SIN3];
	// Flags go only with interface one
	assign cdErrorFlag     = padI[PIN_ERR] & funcQ[PIN_ERR];
	assign cdCFlag         = padI[PIN_CFL] & funcQ[PIN_CFL];

	// ----------------------------------------
	// Interface one capture
	// ----------------------------------------
	logic [31:0] linkWord;
	logic        linkChan;
	logic        linkErr;
	logic        linkCfl;
	logic        linkTog;
	logic        togSync;
	logic        togSeen_q;
	logic        rxPulse;
	logic        statClrNew;
	logic        statClrOvr;
	logic        rxEnable;
	assign rxEnable = funcQ[PIN_SIN1];
	sapi_link_rx uLinkRx (
		.linkClk  (linkClk),
		.rstn     (rstn),
		.enable   (rxEnable),
		.wordClk  (padI[PIN_WCK1]),
		.serIn    (padI[PIN_SIN1]),
		.errIn    (cdErrorFlag),
		.cflIn    (cdCFlag),
		.word_q   (linkWord),
		.chan_q   (linkChan),
		.err_q    (linkErr),
		.cfl_q    (linkCfl),
		.toggle_q (linkTog)
	);

	sapi_sync #(.WIDTH(1)) uTogSync (
		.clk  (clk),
		.rstn (rstn),
		.d    (linkTog),
		.q    (togSync)
	);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			togSeen_q <= 1'b0;
		end else begin
			togSeen_q <= togSync;
		end
	end

	assign rxPulse    = togSync ^ togSeen_q;
	assign statClrNew = wrFire && wAddr_q == OFF_RXSTAT && wStrb_q[0] && wData_q[STAT_NEW];
	assign statClrOvr = wrFire && wAddr_q == OFF_RXSTAT && wStrb_q[0] && wData_q[STAT_OVR];

	// A word arriving with a clear keeps its flag set
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rxWordQ <= 32'h0000_0000;
			statQ   <= STAT_RST;
		end else begin
			if (rxPulse) begin
				rxWordQ           <= linkWord;
				statQ[STAT_CHAN]  <= linkChan;
				statQ[STAT_ERR]   <= linkErr;
				statQ[STAT_CFL]   <= linkCfl;
				statQ[STAT_NEW]   <= 1'b1;
			end else if (statClrNew) begin
				statQ[STAT_NEW]   <= 1'b0;
			end
			if (rxPulse && statQ[STAT_NEW] && !statClrNew) begin
				statQ[STAT_OVR] <= 1'b1;
			end else if (statClrOvr) begin
				statQ[STAT_OVR] <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_FUNC_GPIO: assert property (@(posedge clk) disable iff (!rstn)
		!funcQ[PIN_SOUT2] |-> (padOe[PIN_SOUT2] == gpOeQ[PIN_SOUT2]
			&& padO[PIN_SOUT2] == gpOutQ[PIN_SOUT2]))
		else $error("GPIO mode not honoured");
	AST_BCK_DIR: assert property (@(posedge clk) disable iff (!rstn)
		funcQ[PIN_BCK1] |-> (padOe[PIN_BCK1] == cfgQ[CFG_BCK_OUT]))
		else $error("Bit clock direction wrong");
	AST_BCK_RESET: assert property (@(posedge clk)
		$rose(rstn) |-> (padOe[2:0] == 3'h0))
		else $error("Bit clock drives after reset");
	AST_WCK_RESET: assert property (@(posedge clk)
		$rose(rstn) |-> (padOe[5:3] == 3'h0))
		else $error("Word clock drives after reset");
	AST_WCK_DIR: assert property (@(posedge clk) disable iff (!rstn)
		(funcQ[PIN_WCK1 + 1] && cfgQ[CFG_WCK_OUT + 1]) |-> padOe[PIN_WCK1 + 1])
		else $error("Word clock output not driven");
	AST_CFG_WRITE: assert property (@(posedge clk) disable iff (!rstn)
		(wrFire && wAddr_q == OFF_CFG && wStrb_q[0]) |=> (cfgQ == $past(wData_q[7:0])))
		else $error("Config write lost");
	AST_MCLK_IN: assert property (@(posedge clk) disable iff (!rstn)
		(cfgQ[CFG_MCLK_EN] && funcQ[PIN_WCK3]) |-> !padOe[PIN_WCK3])
		else $error("Master clock pin driven");
	AST_SIN_ROUTE: assert property (@(posedge clk) disable iff (!rstn)
		funcQ[PIN_SIN3] |-> (audioSerIn3 == padI[PIN_SIN3]))
		else $error("Serial input three not routed");
	AST_SIN_INPUT: assert property (@(posedge clk) disable iff (!rstn)
		(funcQ[PIN_SIN1] && funcQ[PIN_SIN3]) |-> (!padOe[PIN_SIN1] && !padOe[PIN_SIN3]))
		else $error("Serial input pin drives");
	AST_SOUT_DRIVE: assert property (@(posedge clk)
		$rose(rstn) |-> (padOe[PIN_SOUT1] && padOe[PIN_SOUT2]))
		else $error("Serial outputs not driving");
	AST_ERR_CAPTURE: assert property (@(posedge clk) disable iff (!rstn)
		rxPulse |=> (statQ[STAT_ERR] == $past(linkErr) && statQ[STAT_NEW]))
		else $error("Error flag not captured");
	AST_CFL_CAPTURE: assert property (@(posedge clk) disable iff (!rstn)
		rxPulse |=> (statQ[STAT_CFL] == $past(linkCfl) && rxWordQ == $past(linkWord)))
		else $error("C-flag not captured");
	AST_WRITE_RESP: assert property (@(posedge clk) disable iff (!rstn)
		wrFire |=> s_axi_bvalid[*1] ##0 !s_axi_awready)
		else $error("Write response missing");

	COV_WRITE: cover property (@(posedge clk) disable iff (!rstn) wrFire ##1 s_axi_bvalid);
	COV_RX:    cover property (@(posedge clk) disable iff (!rstn) rxPulse ##[1:200] rxPulse);
	COV_BCK:   cover property (@(posedge clk) disable iff (!rstn) $rose(padOe[PIN_BCK1]));
	COV_OVR:   cover property (@(posedge clk) disable iff (!rstn) $rose(statQ[STAT_OVR]));
endmodule // sapi_top

/* File: tb/sapi_cd_model.sv */
module sapi_cd_model (
	output logic bitClk,
	output logic wordClk,
	output logic serData,
	output logic errFlag,
	output logic cFlag
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		bitClk = 1'b0;
		wordClk = 1'b0;
		serData = 1'b0;
		errFlag = 1'b0;
		cFlag = 1'b0;
	end

	// ----------------------------------------
	// One bit, data set while clock low
	// ----------------------------------------
	task automatic bitOut(input logic b);
		serData = b;
		#6 bitClk = 1'b1;
		#6 bitClk = 1'b0;
	endtask

	// Word clock flips with the first bit, flags held over the word
	task automatic frame(input logic [31:0] d, input logic e, input logic c);
		errFlag = e;
		cFlag = c;
		wordClk = ~wordClk;
		for (int i = 31; i >= 0; i--) begin
			bitOut(d[i]);
		end
		// Flush edges close the word; their bits start a junk word
		errFlag = 1'b0;
		cFlag = 1'b0;
		wordClk = ~wordClk;
		repeat (6) bitOut(~d[0]);
		// Released lines show no stale value
		serData = ~d[0];
		errFlag = ~e;
		cFlag = ~c;
	endtask
endmodule // sapi_cd_model

/* File: tb/sapi_top_bench.sv */
module sapi_top_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import sapi_pkg::*;

	logic        clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, timerOut;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs, intSerOut;
	logic [11:0] padO, padOe, ext;
	logic [2:0]  intBitClk, intWordClk, bitClkToCore, wordClkToCore;
	logic        masterClkToCore, masterClkSel, audioSerIn1, audioSerIn3;
	logic        cdErrorFlag, cdCFlag, linkClk, wck, sdat, eflg, cd_c_flag_in;
	wire  [11:0] extAll = {cd_c_flag_in, eflg, ext[9:7], sdat, ext[5:4], wck, ext[2:1], linkClk};
	wire  [11:0] padI = (padOe & padO) | (~padOe & extAll);
	int          mismatches, total_checks;

	sapi_top DUT (.clk, .rstn, .linkClk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .padI, .padO, .padOe,
		.intBitClk, .intWordClk, .intSerOut, .timerOut, .bitClkToCore, .wordClkToCore,
		.masterClkToCore, .masterClkSel, .audioSerIn1, .audioSerIn3, .cdErrorFlag,
		.cdCFlag);

	sapi_cd_model cdModel (.bitClk(linkClk), .wordClk(wck), .serData(sdat),
		.errFlag(eflg), .cFlag(cd_c_flag_in));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Both channels offered at once, bready up from the start
	task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw, w, done;
		int n;
		aw = 1;
		w = 1;
		done = 0;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done && n < 100) begin
			@(posedge clk);
			n++;
			if (!aw && !w && s_axi_bvalid === 1'b1) begin
				done = 1;
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
			if (aw && s_axi_awready === 1'b1) begin
				aw = 0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 0;
				s_axi_wvalid <= 1'b0;
			end
		end
		if (!done) mismatches++;
		// One idle edge so the next call never reassigns bready in this step
		@(posedge clk);
	endtask

	task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit ar, done;
		int n;
		ar = 1;
		done = 0;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!done && n < 100) begin
			@(posedge clk);
			n++;
			if (!ar && s_axi_rvalid === 1'b1) begin
				done = 1;
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
			if (ar && s_axi_arready === 1'b1) begin
				ar = 0;
				s_axi_arvalid <= 1'b0;
			end
		end
		if (!done) mismatches++;
		@(posedge clk);
	endtask

	// ----------------------------------------
	// Rows: config in, pin enables out
	// ----------------------------------------
	logic [7:0]  cfgRow [6] = '{8'h00, 8'h07, 8'h38, 8'h2A, 8'h75, 8'hC0};
	logic [5:0]  oeRow  [6] = '{6'h00, 6'h07, 6'h38, 6'h2A, 6'h15, 6'h00};
	logic [31:0] dRow   [4] = '{32'hA5C30F81, 32'h80000001, 32'h7FFEFFFE, 32'hFFFFFFFF};
	logic        eRow   [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	logic        cRow   [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#200000;
		mismatches++;
		finish_test();
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		intBitClk = 3'h5;
		intWordClk = 3'h3;
		intSerOut = 2'h2;
		timerOut = 1'b1;
		ext = 12'h3E3;
		rstn = 1'b0;
		cdModel.bitOut(1'b0);
		repeat (3) @(posedge clk);
		chk(padOe, 12'h300);
		rstn <= 1'b1;
		@(posedge clk);
		axiRd(OFF_FUNC, rd, rs);
		chk(rd, 32'hFFF);
		axiRd(OFF_CFG, rd, rs);
		chk(rd, 32'h0);
		$display("Test reset values done");
		for (int i = 0; i < 6; i++) begin
			axiWr(OFF_CFG, {24'h0, cfgRow[i]}, rs);
			@(posedge clk);
			chk(padOe[5:0], oeRow[i]);
			chk(padO[5:0] & oeRow[i], {intWordClk, intBitClk} & oeRow[i]);
			chk(masterClkSel, cfgRow[i][6]);
			chk(masterClkToCore, extAll[5] & cfgRow[i][6]);
			chk({wordClkToCore, bitClkToCore},
				({intWordClk, intBitClk} & cfgRow[i][5:0]) | (extAll[5:0] & ~cfgRow[i][5:0]));
			chk(padO[9:8], {intSerOut[1], cfgRow[i][7] ? timerOut : intSerOut[0]});
			chk(padOe[9:8], 2'h3);
			axiRd(OFF_CFG, rd, rs);
			chk(rd, {24'h0, cfgRow[i]});
		end
		$display("Test pin direction rows done");
		axiWr(OFF_CFG, 32'h0, rs);
		chk({audioSerIn1, audioSerIn3}, {padI[6], padI[7]});
		for (int j = 0; j < 4; j++) begin
			cdModel.frame(dRow[j], eRow[j], cRow[j]);
			repeat (10) @(posedge clk);
			axiRd(OFF_RXDATA, rd, rs);
			chk(rd, dRow[j]);
			axiRd(OFF_RXSTAT, rd, rs);
			chk(rd[3:0], {1'b1, cRow[j], eRow[j], 1'b1});
			axiWr(OFF_RXSTAT, 32'h18, rs);
		end
		$display("Test link words done");
		// Idle flags now sit high, so a leak past the function select shows
		axiWr(OFF_FUNC, 32'h0, rs);
		axiWr(OFF_GPOUT, 32'hA5C, rs);
		axiWr(OFF_GPOE, 32'h0F0, rs);
		@(posedge clk);
		chk(padOe, 12'h0F0);
		chk(padO & 12'h0F0, 12'h050);
		chk({audioSerIn1, cdErrorFlag, cdCFlag}, 3'h0);
		repeat (3) @(posedge clk);
		axiRd(OFF_GPIN, rd, rs);
		chk(rd[11:0], 12'h050 | (extAll & 12'hF0F));
		// Upper byte strobe only: low byte of the drive value must stay
		s_axi_wstrb <= 4'h2;
		axiWr(OFF_GPOUT, 32'h0000_0FFF, rs);
		s_axi_wstrb <= 4'hF;
		axiRd(OFF_GPOUT, rd, rs);
		chk(rd, 32'h0000_0F5C);
		$display("Test general purpose mode done");
		axiWr(8'h40, 32'h1, rs);
		chk(rs, RESP_SLV);
		axiRd(8'h40, rd, rs);
		chk({rs, rd}, {RESP_SLV, 32'h0});
		$display("Test unmapped access done");
		axiWr(OFF_FUNC, 32'hFFF, rs);
		axiWr(OFF_CFG, 32'h3F, rs);
		rstn <= 1'b0;
		cdModel.bitOut(1'b0);
		@(posedge clk);
		chk(padOe, 12'h300);
		rstn <= 1'b1;
		@(posedge clk);
		axiRd(OFF_CFG, rd, rs);
		chk(rd, 32'h0);
		$display("Test second reset done");
		finish_test();
	end
endmodule // sapi_top_bench
